// File: tbsp_parser.sv
module tbsp_parser (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	output logic byteReady,
	output logic elemValid,
	output tbsp_pkg::tbsp_elem_t elem,
	output logic reservedErr,
	output logic payValid,
	output logic [7:0] payByte,
	input wire logic payDone,
	input wire logic updValid,
	input wire tbsp_pkg::tbsp_upd_t upd,
	output logic analysing,
	output logic [63:0] lastTimestamp,
	output tbsp_pkg::tbsp_hist_t [2:0] history,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	function automatic tbsp_pkg::tbsp_class_t classify(input logic [7:0] h);
		casez (h)
			8'b00000000: classify = tbsp_pkg::CLS_EXT;
			8'b00000001: classify = tbsp_pkg::CLS_INFO;
			8'b0000001?: classify = tbsp_pkg::CLS_TS;
			8'b00000100: classify = tbsp_pkg::CLS_TRACEON;
			8'b00000110: classify = tbsp_pkg::CLS_EXCEPT;
			8'b00001010: classify = tbsp_pkg::CLS_TXSTART;
			8'b00001011: classify = tbsp_pkg::CLS_TXCOMMIT;
			8'b0000110?, 8'b0000111?, 8'b0001????: classify = tbsp_pkg::CLS_CYCCNT;
			8'b00101101: classify = tbsp_pkg::CLS_COMMIT;
			8'b0010111?, 8'b001101??, 8'b00111???: classify = tbsp_pkg::CLS_CANCEL;
			8'b001100??: classify = tbsp_pkg::CLS_MISPRED;
			8'b01110000: classify = tbsp_pkg::CLS_IGNORE;
			8'b0111????: classify = tbsp_pkg::CLS_EVENT;
			8'b1000000?: classify = tbsp_pkg::CLS_CONTEXT;
			8'b1000001?, 8'b10000101, 8'b10000110: classify = tbsp_pkg::CLS_ADDRCTX;
			8'b1001000?, 8'b10010010, 8'b100101??, 8'b1001100?, 8'b1001101?, 8'b10011101,
			8'b10011110: classify = tbsp_pkg::CLS_TARGET;
			8'b1010????: classify = tbsp_pkg::CLS_Q;
			8'b101100??, 8'b1011010?, 8'b1011011?,
			8'b1011100?: classify = tbsp_pkg::CLS_SOURCE;
			8'b11??????: classify = tbsp_pkg::CLS_ATOM;
			default: classify = tbsp_pkg::CLS_RESERVED;
		endcase
	endfunction

	function automatic logic [5:0] atomCount(input logic [7:0] h);
		casez (h)
			8'b1111011?: atomCount = 6'h01;
			8'b110110??: atomCount = 6'h02;
			8'b11111???: atomCount = 6'h03;
			8'b110111??: atomCount = 6'h04;
			8'b11110101, 8'b11010101, 8'b11010110, 8'b11010111: atomCount = 6'h05;
			default: atomCount = {1'b0, h[4:0]} + tbsp_pkg::ATOM6_BASE;
		endcase
	endfunction

	// Headers whose packet is complete in the header byte need no payload phase.
	function automatic logic noPayload(input tbsp_pkg::tbsp_class_t c, input logic [7:0] h);
		unique case (c)
			tbsp_pkg::CLS_TRACEON, tbsp_pkg::CLS_TXSTART, tbsp_pkg::CLS_TXCOMMIT,
			tbsp_pkg::CLS_MISPRED, tbsp_pkg::CLS_ATOM, tbsp_pkg::CLS_IGNORE,
			tbsp_pkg::CLS_RESERVED: noPayload = 1'b1;
			tbsp_pkg::CLS_CANCEL: noPayload = (h[7:1] != 7'b0010111);
			default: noPayload = 1'b0;
		endcase
	endfunction

	localparam int SPEC_W = tbsp_pkg::SPEC_W;
	tbsp_pkg::tbsp_state_t state_reg;
	logic [4:0] zeroRun_reg;
	logic synced;
	logic infoSeen_reg, ctxSeen_reg, addrSeen_reg, inTrans_reg;
	logic [SPEC_W-1:0] specDepth_reg;
	logic [SPEC_W-1:0] specDepth_next;
	logic [31:0] ctrl_reg, cfg_reg, ccThreshold_reg, ctxId_reg, vctxId_reg;
	logic sixtyFour_reg;
	logic [1:0] excLevel_reg, security_reg;
	logic [15:0] errCnt_reg;
	logic resync_reg;
	logic take;
	logic [7:0] b;
	tbsp_pkg::tbsp_class_t hdrCls;
	logic hdrTake, extTake, asyncEnd, huntEnd, badAsync;
	logic emit;
	tbsp_pkg::tbsp_class_t emitCls;

	assign b = byteData;
	assign byteReady = !(state_reg == tbsp_pkg::ST_PAYLOAD && payDone);
	assign take = byteValid && byteReady;
	assign hdrCls = classify(b);
	assign hdrTake = take && state_reg == tbsp_pkg::ST_HEADER;
	assign extTake = take && state_reg == tbsp_pkg::ST_EXT;
	assign asyncEnd = take && state_reg == tbsp_pkg::ST_ASYNC && b != 8'h00;
	assign huntEnd = take && state_reg == tbsp_pkg::ST_HUNT && b == tbsp_pkg::ASYNC_END &&
		zeroRun_reg >= tbsp_pkg::HUNT_MIN_ZEROS;
	assign badAsync = asyncEnd &&
		(b != tbsp_pkg::ASYNC_END || zeroRun_reg < tbsp_pkg::ASYNC_MIN_ZEROS);
	assign synced = state_reg != tbsp_pkg::ST_HUNT;
	assign analysing = synced && infoSeen_reg && ctxSeen_reg && addrSeen_reg;

	always_comb begin
		emit = 1'b0;
		emitCls = hdrCls;
		if (hdrTake && hdrCls != tbsp_pkg::CLS_EXT && hdrCls != tbsp_pkg::CLS_IGNORE) begin
			emit = 1'b1;
		end else if (extTake) begin
			emit = b != 8'h00;
			if (b == tbsp_pkg::EXT_DISCARD) begin
				emitCls = tbsp_pkg::CLS_DISCARD;
			end else if (b == tbsp_pkg::EXT_OVERFLOW) begin
				emitCls = tbsp_pkg::CLS_OVERFLOW;
			end else begin
				emitCls = tbsp_pkg::CLS_RESERVED;
			end
		end else if (asyncEnd) begin
			emit = 1'b1;
			emitCls = badAsync ? tbsp_pkg::CLS_RESERVED : tbsp_pkg::CLS_ASYNC;
		end
	end

	// Bytes before the first complete sync pattern are dropped, so decoding never starts
	// in the middle of a packet.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_reg <= tbsp_pkg::ST_HUNT;
			zeroRun_reg <= 5'h00;
		end else if (resync_reg || !ctrl_reg[tbsp_pkg::CTRL_EN_BIT]) begin
			state_reg <= tbsp_pkg::ST_HUNT;
			zeroRun_reg <= 5'h00;
		end else begin
			unique case (state_reg)
				tbsp_pkg::ST_HUNT: if (take) begin
					if (huntEnd) begin
						state_reg <= tbsp_pkg::ST_HEADER;
					end
					if (b == 8'h00 && zeroRun_reg != 5'h1f) begin
						zeroRun_reg <= zeroRun_reg + 5'h01;
					end else if (b != 8'h00) begin
						zeroRun_reg <= 5'h00;
					end
				end
				tbsp_pkg::ST_HEADER: if (take) begin
					if (hdrCls == tbsp_pkg::CLS_EXT) begin
						state_reg <= tbsp_pkg::ST_EXT;
					end else if (!noPayload(hdrCls, b)) begin
						state_reg <= tbsp_pkg::ST_PAYLOAD;
					end
				end
				tbsp_pkg::ST_EXT: if (take) begin
					state_reg <= (b == 8'h00) ? tbsp_pkg::ST_ASYNC : tbsp_pkg::ST_HEADER;
					zeroRun_reg <= 5'h01;
				end
				tbsp_pkg::ST_ASYNC: if (take) begin
					if (b != 8'h00) begin
						state_reg <= tbsp_pkg::ST_HEADER;
					end else if (zeroRun_reg != 5'h1f) begin
						zeroRun_reg <= zeroRun_reg + 5'h01;
					end
				end
				tbsp_pkg::ST_PAYLOAD: if (payDone) begin
					state_reg <= tbsp_pkg::ST_HEADER;
				end
				default: state_reg <= tbsp_pkg::ST_HUNT;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			elemValid <= 1'b0;
			elem <= '0;
			reservedErr <= 1'b0;
			payValid <= 1'b0;
			payByte <= 8'h00;
		end else begin
			elemValid <= emit;
			reservedErr <= emit && emitCls == tbsp_pkg::CLS_RESERVED;
			payValid <= take && state_reg == tbsp_pkg::ST_PAYLOAD;
			if (emit) begin
				elem <= '{cls: emitCls, header: b};
			end
			if (take && state_reg == tbsp_pkg::ST_PAYLOAD) begin
				payByte <= b;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			infoSeen_reg <= 1'b0;
			ctxSeen_reg <= 1'b0;
			addrSeen_reg <= 1'b0;
		end else if (resync_reg || !synced) begin
			infoSeen_reg <= 1'b0;
			ctxSeen_reg <= 1'b0;
			addrSeen_reg <= 1'b0;
		end else if (emit) begin
			if (emitCls == tbsp_pkg::CLS_INFO) begin
				infoSeen_reg <= 1'b1;
			end
			if (emitCls == tbsp_pkg::CLS_CANCEL && !analysing) begin
				ctxSeen_reg <= 1'b0;
				addrSeen_reg <= 1'b0;
			end else if (infoSeen_reg) begin
				if (emitCls == tbsp_pkg::CLS_CONTEXT || emitCls == tbsp_pkg::CLS_ADDRCTX) begin
					ctxSeen_reg <= 1'b1;
				end
				if (emitCls == tbsp_pkg::CLS_TARGET || emitCls == tbsp_pkg::CLS_ADDRCTX) begin
					addrSeen_reg <= 1'b1;
				end
			end
		end
	end

	always_comb begin
		logic [SPEC_W:0] sum;
		logic [SPEC_W-1:0] dec;
		sum = {1'b0, specDepth_reg};
		dec = '0;
		if (hdrTake && hdrCls == tbsp_pkg::CLS_ATOM) begin
			sum = sum + {{(SPEC_W-5){1'b0}}, atomCount(b)};
		end
		if (hdrTake && hdrCls == tbsp_pkg::CLS_CANCEL && b[7:3] == 5'b00111) begin
			dec = {{(SPEC_W-3){1'b0}}, {1'b0, b[2:1]} + 3'h2};
		end
		if (updValid && upd.kind == tbsp_pkg::UPD_SPECDEC) begin
			dec = dec + upd.data[SPEC_W-1:0];
		end
		if (updValid && upd.kind == tbsp_pkg::UPD_INFO && !infoSeen_reg) begin
			specDepth_next = upd.data[SPEC_W-1:0];
		end else if (sum > {1'b0, dec}) begin
			specDepth_next = sum[SPEC_W-1:0] - dec;
		end else begin
			specDepth_next = '0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			specDepth_reg <= '0;
			inTrans_reg <= 1'b0;
		end else if (emit && emitCls == tbsp_pkg::CLS_DISCARD) begin
			specDepth_reg <= '0;
			inTrans_reg <= 1'b0;
		end else begin
			specDepth_reg <= specDepth_next;
			if (emit && emitCls == tbsp_pkg::CLS_TXSTART) begin
				inTrans_reg <= 1'b1;
			end else if (emit && emitCls == tbsp_pkg::CLS_TXCOMMIT) begin
				inTrans_reg <= 1'b0;
			end
		end
	end

	// The payload decoder rebuilds compressed fields against these copies and reports the
	// expanded values back; the parser only stores them.
	for (genvar i = 0; i < tbsp_pkg::HIST_DEPTH; i++) begin : gHist
		always_ff @(posedge clk_sys or negedge nrst) begin
			if (!nrst) begin
				history[i] <= '0;
			end else if (updValid && upd.kind == tbsp_pkg::UPD_INFO) begin
				history[i] <= '{isa: tbsp_pkg::ISA_DEFAULT, addr: 64'h0};
			end else if (updValid && upd.kind == tbsp_pkg::UPD_ADDR) begin
				if (i == 0) begin
					history[i] <= '{isa: upd.aux[1:0], addr: upd.data};
				end else begin
					history[i] <= history[(i > 0) ? i - 1 : 0];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lastTimestamp <= 64'h0;
			ctxId_reg <= 32'h0;
			vctxId_reg <= 32'h0;
			sixtyFour_reg <= 1'b0;
			excLevel_reg <= 2'h0;
			security_reg <= 2'h0;
			ccThreshold_reg <= 32'h0;
		end else if (updValid) begin
			unique case (upd.kind)
				tbsp_pkg::UPD_TS: lastTimestamp <= upd.data;
				tbsp_pkg::UPD_CTX: begin
					ctxId_reg <= upd.data[31:0];
					vctxId_reg <= upd.data[63:32];
					sixtyFour_reg <= upd.aux[0];
					excLevel_reg <= upd.aux[2:1];
					security_reg <= upd.aux[4:3];
				end
				tbsp_pkg::UPD_INFO: if (!infoSeen_reg) begin
					ccThreshold_reg <= upd.aux[0] ? upd.data[31:0] : 32'h0;
				end
				default: begin
				end
			endcase
		end
	end

	logic awHeld_reg, wHeld_reg, rvalid_reg, bvalid_reg;
	logic [7:0] awAddr_reg;
	logic [31:0] wData_reg, wMask, rdMux;
	logic [3:0] wStrb_reg;
	logic wrFire, rdOk;

	assign s_axi_awready = !awHeld_reg;
	assign s_axi_wready = !wHeld_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign wrFire = awHeld_reg && wHeld_reg && !bvalid_reg;
	assign wMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0;
			wStrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			s_axi_bresp <= tbsp_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !awHeld_reg) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr & 8'hfc;
			end else if (wrFire) begin
				awHeld_reg <= 1'b0;
			end
			if (s_axi_wvalid && !wHeld_reg) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end else if (wrFire) begin
				wHeld_reg <= 1'b0;
			end
			if (wrFire) begin
				bvalid_reg <= 1'b1;
				s_axi_bresp <= (awAddr_reg <= tbsp_pkg::OFS_HIST_HI) ?
					tbsp_pkg::RESP_OKAY : tbsp_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Settings are static for a session; software should change them only while disabled.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= tbsp_pkg::CTRL_RESET;
			cfg_reg <= tbsp_pkg::CFG_RESET;
			resync_reg <= 1'b0;
		end else begin
			resync_reg <= wrFire && awAddr_reg == tbsp_pkg::OFS_CTRL && wStrb_reg[0] &&
				wData_reg[tbsp_pkg::CTRL_RESYNC_BIT];
			if (wrFire && awAddr_reg == tbsp_pkg::OFS_CTRL) begin
				ctrl_reg[0] <= wMask[0] ? wData_reg[0] : ctrl_reg[0];
			end
			if (wrFire && awAddr_reg == tbsp_pkg::OFS_CFG) begin
				cfg_reg <= (cfg_reg & ~wMask) | (wData_reg & wMask);
			end
		end
	end

	// A reserved event in the clearing cycle survives, so no error is lost to the clear.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			errCnt_reg <= 16'h0;
		end else if (wrFire && awAddr_reg == tbsp_pkg::OFS_ERRCNT) begin
			errCnt_reg <= {15'h0, reservedErr};
		end else if (reservedErr && errCnt_reg != 16'hffff) begin
			errCnt_reg <= errCnt_reg + 16'h1;
		end
	end

	always_comb begin
		rdOk = 1'b1;
		unique case (s_axi_araddr & 8'hfc)
			tbsp_pkg::OFS_CTRL: rdMux = ctrl_reg;
			tbsp_pkg::OFS_CFG: rdMux = cfg_reg;
			tbsp_pkg::OFS_STATUS: rdMux = {specDepth_reg, 3'h0,
				specDepth_reg > cfg_reg[tbsp_pkg::CFG_MAXSPEC_LSB +: SPEC_W], security_reg,
				excLevel_reg, 1'b0, sixtyFour_reg, inTrans_reg, addrSeen_reg, ctxSeen_reg,
				infoSeen_reg, analysing, synced};
			tbsp_pkg::OFS_ERRCNT: rdMux = {16'h0, errCnt_reg};
			tbsp_pkg::OFS_TS_LO: rdMux = lastTimestamp[31:0];
			tbsp_pkg::OFS_TS_HI: rdMux = lastTimestamp[63:32];
			tbsp_pkg::OFS_CTXID: rdMux = ctxId_reg;
			tbsp_pkg::OFS_VCTXID: rdMux = vctxId_reg;
			tbsp_pkg::OFS_CCTHR: rdMux = ccThreshold_reg;
			tbsp_pkg::OFS_HIST_LO: rdMux = history[0].addr[31:0];
			tbsp_pkg::OFS_HIST_HI: rdMux = history[0].addr[63:32];
			default: begin
				rdMux = 32'h0;
				rdOk = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rvalid_reg <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= tbsp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			s_axi_rdata <= rdMux;
			s_axi_rresp <= rdOk ? tbsp_pkg::RESP_OKAY : tbsp_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	sequence hdrSeen(logic [7:0] v);
		hdrTake && b == v;
	endsequence

	sequence elemOut(tbsp_pkg::tbsp_class_t c);
		elemValid && elem.cls == c;
	endsequence

	analyse_gate_a: assert property (($rose(ctxSeen_reg) || $rose(addrSeen_reg)) |-> infoSeen_reg)
		else $error("context or address counted before trace info");
	cancel_wait_a: assert property (emit && emitCls == tbsp_pkg::CLS_CANCEL && !analysing && !resync_reg
		|=> !ctxSeen_reg && !addrSeen_reg && !analysing)
		else $error("cancel before analysis kept context or address");
	info_once_a: assert property (infoSeen_reg && updValid && upd.kind == tbsp_pkg::UPD_INFO
		|=> $stable(ccThreshold_reg))
		else $error("later trace info changed the threshold");
	hist_shift_a: assert property (updValid && upd.kind == tbsp_pkg::UPD_ADDR
		|=> history[2] == $past(history[1]) && history[0].addr == $past(upd.data))
		else $error("address history did not shift");
	info_clear_a: assert property (updValid && upd.kind == tbsp_pkg::UPD_INFO
		|=> history[2].addr == 64'h0 && history[0].isa == tbsp_pkg::ISA_DEFAULT)
		else $error("trace info did not clear the history");
	atom_depth_a: assert property (hdrSeen(8'hf6) ##0 !updValid
		|=> specDepth_reg == $past(specDepth_reg) + 16'h1)
		else $error("single atom did not add one to the depth");
	discard_zero_a: assert property (extTake && b == tbsp_pkg::EXT_DISCARD
		|=> elemOut(tbsp_pkg::CLS_DISCARD) ##0 specDepth_reg == 16'h0 && !inTrans_reg)
		else $error("discard did not clear the depth");
	ts_keep_a: assert property (updValid && upd.kind == tbsp_pkg::UPD_TS
		|=> lastTimestamp == $past(upd.data))
		else $error("timestamp not kept");
	hunt_only_a: assert property (take && state_reg == tbsp_pkg::ST_HUNT && !huntEnd
		|=> state_reg == tbsp_pkg::ST_HUNT && !elemValid)
		else $error("decoding began without a sync pattern");
	async_bad_a: assert property (asyncEnd && b != tbsp_pkg::ASYNC_END
		|=> elemOut(tbsp_pkg::CLS_RESERVED) ##0 reservedErr)
		else $error("bad sync terminator not reported");
	ignore_hdr_a: assert property (hdrSeen(tbsp_pkg::HDR_IGNORE) |=> !elemValid)
		else $error("ignored header was emitted");
	cancel_class_a: assert property (hdrSeen(8'h34) |=> elemOut(tbsp_pkg::CLS_CANCEL))
		else $error("cancel header misclassified");
endmodule

// File: tbsp_pkg.sv
package tbsp_pkg;
	localparam int ADDR_W = 8;
	localparam int SPEC_W = 16;
	localparam int HIST_DEPTH = 3;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_ERRCNT = 8'h0c;
	localparam logic [7:0] OFS_TS_LO = 8'h10;
	localparam logic [7:0] OFS_TS_HI = 8'h14;
	localparam logic [7:0] OFS_CTXID = 8'h18;
	localparam logic [7:0] OFS_VCTXID = 8'h1c;
	localparam logic [7:0] OFS_CCTHR = 8'h20;
	localparam logic [7:0] OFS_HIST_LO = 8'h24;
	localparam logic [7:0] OFS_HIST_HI = 8'h28;
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_RESYNC_BIT = 1;
	localparam int CFG_COMMIT_BIT = 0;
	localparam int CFG_TRANS_BIT = 1;
	localparam int CFG_VMIDSZ_LSB = 2;
	localparam int CFG_MAXSPEC_LSB = 16;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [4:0] ASYNC_MIN_ZEROS = 5'h0a;
	localparam logic [4:0] HUNT_MIN_ZEROS = 5'h0b;
	localparam logic [7:0] ASYNC_END = 8'h80;
	localparam logic [7:0] EXT_DISCARD = 8'h03;
	localparam logic [7:0] EXT_OVERFLOW = 8'h05;
	localparam logic [7:0] HDR_IGNORE = 8'h70;
	localparam logic [1:0] ISA_DEFAULT = 2'h0;
	localparam logic [5:0] ATOM6_BASE = 6'h03;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [4:0] {
		CLS_ASYNC = 5'h00, CLS_DISCARD = 5'h01, CLS_OVERFLOW = 5'h02, CLS_INFO = 5'h03,
		CLS_TS = 5'h04, CLS_TRACEON = 5'h05, CLS_EXCEPT = 5'h06, CLS_TXSTART = 5'h07,
		CLS_TXCOMMIT = 5'h08, CLS_CYCCNT = 5'h09, CLS_COMMIT = 5'h0a, CLS_CANCEL = 5'h0b,
		CLS_MISPRED = 5'h0c, CLS_EVENT = 5'h0d, CLS_CONTEXT = 5'h0e, CLS_ADDRCTX = 5'h0f,
		CLS_TARGET = 5'h10, CLS_Q = 5'h11, CLS_SOURCE = 5'h12, CLS_ATOM = 5'h13,
		CLS_RESERVED = 5'h14, CLS_IGNORE = 5'h15, CLS_EXT = 5'h16
	} tbsp_class_t;
	typedef enum logic [2:0] {
		ST_HUNT = 3'h0, ST_HEADER = 3'h1, ST_EXT = 3'h2, ST_ASYNC = 3'h3, ST_PAYLOAD = 3'h4
	} tbsp_state_t;
	typedef enum logic [2:0] {
		UPD_ADDR = 3'h0, UPD_TS = 3'h1, UPD_CTX = 3'h2, UPD_INFO = 3'h3, UPD_SPECDEC = 3'h4
	} tbsp_upd_kind_t;
	typedef struct packed {
		tbsp_upd_kind_t kind;
		logic [63:0] data;
		logic [7:0] aux;
	} tbsp_upd_t;
	typedef struct packed {
		tbsp_class_t cls;
		logic [7:0] header;
	} tbsp_elem_t;
	typedef struct packed {
		logic [1:0] isa;
		logic [63:0] addr;
	} tbsp_hist_t;
endpackage

// File: tbsp_trace_src.sv
module tbsp_trace_src (
	input wire logic clk_sys,
	input wire logic byteReady,
	output logic byteValid,
	output logic [7:0] byteData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		byteValid = 1'b0;
		byteData = 8'h5a;
	end
	// A released line shows the inverse of the last byte so stale data never looks valid.
	task automatic send(input logic [7:0] b);
		@(posedge clk_sys);
		byteValid <= 1'b1;
		byteData <= b;
		do @(negedge clk_sys); while (byteReady !== 1'b1);
		@(posedge clk_sys);
		byteValid <= 1'b0;
		byteData <= ~b;
	endtask
endmodule

// File: tb_trace_byte_stream_parser.sv
module tb_trace_byte_stream_parser;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic byteValid, byteReady, elemValid, reservedErr, payValid, analysing, seenErr;
	logic payDone = 1'b0;
	logic updValid = 1'b0;
	logic [7:0] byteData, payByte;
	logic [63:0] lastTimestamp;
	tbsp_pkg::tbsp_elem_t elem;
	tbsp_pkg::tbsp_upd_t upd = '0;
	tbsp_pkg::tbsp_hist_t [2:0] history;
	tbsp_pkg::tbsp_class_t seenCls;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int fail_count = 0, checks = 0, cycles = 0;
	always #12.5 clk_sys = ~clk_sys;
	tbsp_trace_src u_src (.clk_sys(clk_sys), .byteReady(byteReady), .byteValid(byteValid),
		.byteData(byteData));
	tbsp_parser u_dut (.clk_sys(clk_sys), .nrst(nrst), .byteValid(byteValid), .byteData(byteData),
		.byteReady(byteReady), .elemValid(elemValid), .elem(elem), .reservedErr(reservedErr),
		.payValid(payValid), .payByte(payByte), .payDone(payDone), .updValid(updValid), .upd(upd),
		.analysing(analysing), .lastTimestamp(lastTimestamp), .history(history),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
		if (elemValid === 1'b1) begin
			seenCls <= elem.cls;
			seenErr <= reservedErr;
		end
	end
	task automatic summarize();
		$display("Counts: checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic checkVal(input logic [65:0] exp, input logic [65:0] got, input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic tw, ta, done;
		@(posedge clk_sys);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		done = 1'b0;
		while (!done) begin
			@(negedge clk_sys);
			ta = awvalid && awready === 1'b1;
			tw = wvalid && wready === 1'b1;
			done = bvalid === 1'b1;
			r = bresp;
			@(posedge clk_sys);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
	endtask
	task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, done;
		@(posedge clk_sys);
		{araddr, arvalid, rready} <= {a, 2'b11};
		done = 1'b0;
		while (!done) begin
			@(negedge clk_sys);
			ta = arvalid && arready === 1'b1;
			done = rvalid === 1'b1;
			{r, d} = {rresp, rdata};
			@(posedge clk_sys);
			if (ta) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
	endtask
	task automatic syncUp();
		repeat (12) u_src.send(8'h00);
		u_src.send(tbsp_pkg::ASYNC_END);
	endtask
	// Each packet is preceded by a fresh sync, so a refused packet cannot derail the next.
	task automatic pkt(input logic [7:0] b[$], input tbsp_pkg::tbsp_class_t exp);
		syncUp();
		repeat (2) @(negedge clk_sys);
		seenCls = tbsp_pkg::CLS_EXT;
		foreach (b[i]) u_src.send(b[i]);
		repeat (3) @(negedge clk_sys);
		checkVal(exp, seenCls, "class");
		checkVal(exp == tbsp_pkg::CLS_RESERVED, seenErr, "reserved flag");
		@(posedge clk_sys);
		payDone <= 1'b1;
		@(posedge clk_sys);
		payDone <= 1'b0;
	endtask
	task automatic sendUpd(input tbsp_pkg::tbsp_upd_kind_t k, input logic [63:0] d);
		@(posedge clk_sys);
		updValid <= 1'b1;
		upd <= '{k, d, 8'h01};
		@(posedge clk_sys);
		updValid <= 1'b0;
	endtask
	task automatic testAxi();
		logic [31:0] d;
		logic [1:0] r;
		axiRead(tbsp_pkg::OFS_CTRL, d, r);
		checkVal(tbsp_pkg::CTRL_RESET, d, "ctrl reset");
		axiWrite(tbsp_pkg::OFS_CFG, 32'h0003_0015, r);
		checkVal(tbsp_pkg::RESP_OKAY, r, "write resp");
		axiRead(tbsp_pkg::OFS_CFG, d, r);
		checkVal(32'h0003_0015, d, "static settings");
		axiRead(8'h40, d, r);
		checkVal({tbsp_pkg::RESP_SLVERR, 32'h0}, {r, d}, "unmapped read");
		$display("TEST axi done");
	endtask
	task automatic testClasses();
		logic [7:0] h[16] = '{8'hf6, 8'hc0, 8'h2f, 8'h34, 8'h3c, 8'h71, 8'h90, 8'h9e, 8'ha5,
			8'hb0, 8'hb9, 8'h04, 8'h80, 8'h82, 8'h08, 8'h9c};
		tbsp_pkg::tbsp_class_t c[16] = '{tbsp_pkg::CLS_ATOM, tbsp_pkg::CLS_ATOM,
			tbsp_pkg::CLS_CANCEL, tbsp_pkg::CLS_CANCEL, tbsp_pkg::CLS_CANCEL, tbsp_pkg::CLS_EVENT,
			tbsp_pkg::CLS_TARGET, tbsp_pkg::CLS_TARGET, tbsp_pkg::CLS_Q, tbsp_pkg::CLS_SOURCE,
			tbsp_pkg::CLS_SOURCE, tbsp_pkg::CLS_TRACEON, tbsp_pkg::CLS_CONTEXT,
			tbsp_pkg::CLS_ADDRCTX, tbsp_pkg::CLS_RESERVED, tbsp_pkg::CLS_RESERVED};
		foreach (h[i]) pkt({h[i]}, c[i]);
		$display("TEST header classes done");
	endtask
	task automatic testExt();
		logic [7:0] q[$];
		pkt({8'h00, 8'h03}, tbsp_pkg::CLS_DISCARD);
		pkt({8'h00, 8'h05}, tbsp_pkg::CLS_OVERFLOW);
		pkt({8'h00, 8'h07}, tbsp_pkg::CLS_RESERVED);
		repeat (10) q.push_back(8'h00);
		pkt({q, tbsp_pkg::ASYNC_END}, tbsp_pkg::CLS_RESERVED);
		pkt({q, 8'h00, 8'h00, 8'h81}, tbsp_pkg::CLS_RESERVED);
		$display("TEST extension done");
	endtask
	task automatic testHistory();
		for (int i = 0; i < 3; i++) sendUpd(tbsp_pkg::UPD_ADDR, 64'h100 + i);
		sendUpd(tbsp_pkg::UPD_TS, 64'hfedc_ba98_7654_3210);
		@(negedge clk_sys);
		checkVal({2'h1, 64'h102}, history[0], "newest address");
		checkVal({2'h1, 64'h100}, history[2], "oldest address");
		checkVal(64'hfedc_ba98_7654_3210, lastTimestamp, "timestamp");
		pkt({8'h01}, tbsp_pkg::CLS_INFO);
		sendUpd(tbsp_pkg::UPD_INFO, 64'h0);
		@(negedge clk_sys);
		for (int i = 0; i < 3; i++) checkVal({tbsp_pkg::ISA_DEFAULT, 64'h0}, history[i], "hist");
		$display("TEST history done");
	endtask
	// Runs after trace info has been seen, so only context and address gate analysis.
	task automatic testStart();
		pkt({8'h80, 8'h3c}, tbsp_pkg::CLS_CONTEXT);
		checkVal(8'h3c, payByte, "payload byte");
		pkt({8'h34}, tbsp_pkg::CLS_CANCEL);
		pkt({8'h90}, tbsp_pkg::CLS_TARGET);
		checkVal(1'b0, analysing, "analysis after cancel");
		pkt({8'h80}, tbsp_pkg::CLS_CONTEXT);
		checkVal(1'b1, analysing, "analysis started");
		$display("TEST start-up done");
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		nrst <= 1'b1;
		testAxi();
		testClasses();
		testExt();
		testHistory();
		testStart();
		summarize();
	end
endmodule
